/* test_tws_shaper.sv */
// Self-checking bench: AHB-Lite master, pulse driver and line sink.
// Assumes a zero wait state slave; hready is the slave's hreadyout.
`timescale 1ns/1ps
module test_tws_shaper;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic pulse_req = 1'b0;
    logic pulse_neg = 1'b0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [6:0] line_output_pair;
    logic line_output_valid;
    tws_pkg::tws_src_e line_output_source;
    logic [6:0] wave_q [64];
    logic [6:0] got_q;
    logic [6:0] ram_m [64];
    logic [6:0] exp_w [64];
    logic [3:0] rf_t [4] = '{4'h1, 4'h1, 4'h5, 4'h2};
    logic [5:0] sc_t [4] = '{6'h24, 6'h21, 6'h30, 6'h3f};
    logic [15:0] seed = 16'h0007;
    logic [31:0] r;
    int error_cnt = 0;
    int num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    tws_shaper i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pulse_req(pulse_req), .pulse_neg(pulse_neg), .line_output_pair(line_output_pair),
        .line_output_valid(line_output_valid), .line_output_source(line_output_source));
    tws_line_sink i_sink (.clk_sys(clk_sys), .rst_b(rst_b),
        .line_output_pair(line_output_pair), .line_output_valid(line_output_valid),
        .wave_q(wave_q), .got_q(got_q));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [1:0] exp_src(input logic [3:0] s);
        if (s[3:2] == 2'h3) return 2'h3;
        if (s <= 4'h6) return 2'h1;
        if (s >= 4'h9) return 2'h2;
        return 2'h0;
    endfunction : exp_src

    function automatic logic [5:0] scaled(input logic [5:0] m, input logic [5:0] sc,
            input logic [3:0] rf);
        int std_v;
        int pct;
        int v;
        std_v = (rf == 4'h1) ? 6'h21 : 6'h36;
        pct = (rf == 4'h1) ? 3 : 2;
        v = int'(m) * (100 + (int'(sc) - std_v) * pct) / 100;
        return (v > 63) ? 6'h3f : 6'(v);
    endfunction : scaled

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus

    task automatic poll(input logic [7:0] a, input int b);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0);
            n++;
        end while (r[b] !== 1'b0 && n < 100);
        check("busy or done bit", r[b], 32'h0);
    endtask : poll

    task automatic ram_op(input logic rw, input logic [5:0] a, input logic [6:0] d);
        bus(1'b1, tws_pkg::ACCESS_OFS, {15'h0, 1'b1, 2'h0, a, rw, d});
        poll(tws_pkg::ACCESS_OFS, tws_pkg::ACC_DONE_BIT);
    endtask : ram_op

    task automatic ctrl(input logic [3:0] rf, input logic [5:0] sc, input logic [3:0] sel);
        bus(1'b1, tws_pkg::CTRL_OFS, {12'h0, rf, 2'h0, sc, 4'h0, sel});
    endtask : ctrl

    // A second request mid-pulse must be ignored
    task automatic play(input logic neg);
        pulse_req <= 1'b1;
        pulse_neg <= neg;
        @(posedge clk_sys);
        pulse_req <= 1'b0;
        repeat (9) @(posedge clk_sys);
        pulse_req <= 1'b1;
        @(posedge clk_sys);
        pulse_req <= 1'b0;
        repeat (70) @(posedge clk_sys);
        check("sample count", got_q, 7'h40);
    endtask : play

    task automatic cmp(input string what);
        for (int k = 0; k < 64; k++) check(what, wave_q[k], exp_w[k]);
        $display("test %s done", what);
    endtask : cmp

    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        bus(1'b0, tws_pkg::CTRL_OFS, 32'h0);
        check("ctrl reset", r, 32'h0);
        bus(1'b0, tws_pkg::STATUS_OFS, 32'h0);
        check("status reset", r, 32'h10);
        bus(1'b1, 8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped", r, 32'h0);
        $display("test reset done");
        for (int s = 0; s < 16; s++) begin
            ctrl(4'h0, 6'h00, 4'(s));
            bus(1'b0, tws_pkg::STATUS_OFS, 32'h0);
            check("source", r[5:4], exp_src(4'(s)));
        end
        $display("test select done");
        // Full scale value must leave preset shapes untouched
        for (int t = 0; t < 3; t++) begin
            ctrl(4'h1, 6'h3f, (t == 2) ? 4'h7 : 4'(t));
            for (int k = 0; k < 64; k++)
                exp_w[k] = (t == 2 || k < 3 || k > 11) ? 7'h00 : (k == 3) ?
                    (t ? 7'b0001111 : 7'b0001100) : (t ? 7'b0111100 : 7'b0110000);
            play(1'b0);
            check("preset source", line_output_source, exp_src((t == 2) ? 4'h7 : 4'(t)));
            cmp("preset");
        end
        ctrl(4'h0, 6'h00, 4'h2);
        play(1'b0);
        check("t1 first", wave_q[0], 7'b0010111);
        check("t1 ui1 end", wave_q[15], 7'b1000011);
        check("t1 ui2", wave_q[16], 7'b1000010);
        $display("test t1 done");
        for (int k = 0; k < 64; k++) begin
            seed = lfsr(seed);
            ram_m[k] = {seed[6], 6'(seed[5:0] % 63) + 6'h01};
            ram_op(1'b0, 6'(k), ram_m[k]);
        end
        for (int k = 0; k < 8; k++) begin
            logic [5:0] a;
            seed = lfsr(seed);
            a = k ? seed[5:0] : 6'h3f;
            ram_op(1'b1, a, 7'h00);
            check("ram read", r[6:0], ram_m[a]);
        end
        $display("test ram done");
        for (int i = 0; i < 4; i++) begin
            ctrl(rf_t[i], sc_t[i], 4'hc + 4'(i));
            for (int k = 0; k < 64; k++)
                exp_w[k] = {ram_m[k][6] ^ i[0], scaled(ram_m[k][5:0], sc_t[i], rf_t[i])};
            play(i[0]);
            check("user source", line_output_source, 2'h3);
            cmp("user");
        end
        bus(1'b1, tws_pkg::COPY_OFS, 32'h00000101);
        poll(tws_pkg::STATUS_OFS, tws_pkg::STAT_BUSY_BIT);
        ram_op(1'b1, 6'h03, 7'h00);
        check("copy edge", r[6:0], 7'b0001111);
        ram_op(1'b1, 6'h0b, 7'h00);
        check("copy top", r[6:0], 7'b0111100);
        $display("test copy done");
        close_out();
    end
endmodule : test_tws_shaper

/* tws_line_sink.sv */
// Line driver and cable model: captures the samples of each pulse.
// Assumes one sample per clk_sys while the shaper's valid is high.
`timescale 1ns/1ps
module tws_line_sink (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [tws_pkg::SAMP_W-1:0] line_output_pair,
    input wire logic line_output_valid,
    output logic [tws_pkg::SAMP_W-1:0] wave_q [64],
    output logic [6:0] got_q
);
    logic was_q;
    logic [6:0] idx;
    // A new burst restarts the capture at slot zero
    assign idx = was_q ? got_q : 7'h00;
    always_ff @(posedge clk_sys) begin
        was_q <= rst_b && line_output_valid;
        if (!rst_b) begin
            got_q <= 7'h00;
        end else if (line_output_valid) begin
            wave_q[idx[5:0]] <= line_output_pair;
            got_q <= idx + 7'h01;
        end
    end
endmodule : tws_line_sink

/* tws_pkg.sv */
// Shared constants and types for the transmit waveform shaper.
// Assumes a 32-bit AHB-Lite register port and one sample per clock on playback.
package tws_pkg;

    localparam int unsigned ADDR_W = 6;
    localparam int unsigned SAMP_W = 7;
    localparam int unsigned MAG_W = 6;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned SCALE_W = 6;
    localparam int unsigned TMPL_W = 4;
    localparam int unsigned NUM_TMPL = 12;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] ACCESS_OFS = 8'h04;
    localparam logic [7:0] COPY_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // Control register fields
    localparam int unsigned CTRL_SEL_LSB = 0;
    localparam int unsigned CTRL_SCALE_LSB = 8;
    localparam int unsigned CTRL_REF_LSB = 16;
    // Access register fields
    localparam int unsigned ACC_DATA_LSB = 0;
    localparam int unsigned ACC_RW_BIT = 7;
    localparam int unsigned ACC_SAMP_LSB = 8;
    localparam int unsigned ACC_UI_LSB = 12;
    localparam int unsigned ACC_DONE_BIT = 16;
    // Copy register fields
    localparam int unsigned COPY_TMPL_LSB = 0;
    localparam int unsigned COPY_GO_BIT = 8;
    // Status register fields
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_SRC_LSB = 4;

    // Pulse select codes
    localparam logic [3:0] SEL_E1_75 = 4'h0;
    localparam logic [3:0] SEL_E1_120 = 4'h1;
    localparam logic [3:0] SEL_T1_133 = 4'h2;
    localparam logic [3:0] SEL_T1_655 = 4'h6;
    localparam logic [3:0] SEL_LBO_7P5 = 4'h9;
    localparam logic [3:0] SEL_LBO_22P5 = 4'hb;
    localparam logic [1:0] SEL_USER_TOP = 2'h3;

    // Template numbers in the reference ROM
    localparam logic [3:0] TMPL_E1_75 = 4'h0;
    localparam logic [3:0] TMPL_E1_120 = 4'h1;
    localparam logic [3:0] TMPL_T1_133 = 4'h2;
    localparam logic [3:0] TMPL_J1 = 4'h7;
    localparam logic [3:0] TMPL_LBO_0 = 4'h8;
    localparam logic [3:0] TMPL_LBO_7P5 = 4'h9;

    // Standard scaling values and percent per step
    localparam logic [5:0] SCALE_STD_E1_120 = 6'h21;
    localparam logic [5:0] SCALE_STD_T1 = 6'h36;
    localparam int PCT_E1_120 = 3;
    localparam int PCT_T1 = 2;
    localparam int PCT_FULL = 100;

    // Sample values of the E1 templates
    localparam logic [6:0] E1_75_EDGE = 7'h0c;
    localparam logic [6:0] E1_75_TOP = 7'h30;
    localparam logic [6:0] E1_120_EDGE = 7'h0f;
    localparam logic [6:0] E1_120_TOP = 7'h3c;
    localparam logic [5:0] E1_EDGE_IDX = 6'h03;
    localparam logic [5:0] E1_TOP_LAST = 6'h0b;

    localparam logic [6:0] SAMP_ZERO = 7'h00;
    localparam logic [5:0] ADDR_LAST = 6'h3f;

    typedef enum logic [1:0] {SRC_OFF, SRC_PRESET, SRC_LBO, SRC_USER} tws_src_e;

    typedef struct packed {
        logic [3:0] ref_tmpl;
        logic [5:0] scale;
        logic [3:0] sel;
    } tws_ctrl_s;

    typedef struct packed {
        logic done;
        logic [1:0] ui;
        logic [3:0] samp;
        logic rw;
        logic [6:0] data;
    } tws_access_s;

endpackage : tws_pkg

/* tws_sample_ram.sv */
// 64-entry waveform sample memory, one write port and two read ports.
// Read data are registered; both ports see a write one cycle later.
`timescale 1ns/1ps
module tws_sample_ram #(
    parameter int unsigned DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [tws_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [tws_pkg::SAMP_W-1:0] wr_data,
    input wire logic [tws_pkg::ADDR_W-1:0] rd_addr_a,
    output logic [tws_pkg::SAMP_W-1:0] rd_data_a,
    input wire logic [tws_pkg::ADDR_W-1:0] rd_addr_b,
    output logic [tws_pkg::SAMP_W-1:0] rd_data_b
);
    logic [tws_pkg::SAMP_W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_a <= mem[rd_addr_a];
        rd_data_b <= mem[rd_addr_b];
    end
endmodule : tws_sample_ram

/* tws_shaper.sv */
// Transmit waveform shaper and line build-out select for one line.
// AHB-Lite slave for control; plays 64 sub-phase samples per pulse request.
// Assumes pulse_req and pulse_neg come from logic on clk_sys.
`timescale 1ns/1ps
module tws_shaper #(
    parameter int unsigned RAM_DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pulse_req,
    input wire logic pulse_neg,
    output logic [tws_pkg::SAMP_W-1:0] line_output_pair,
    output logic line_output_valid,
    output tws_pkg::tws_src_e line_output_source
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_COPY} tws_state_e;

    tws_pkg::tws_ctrl_s ctrl_q, ctrl_d;
    tws_pkg::tws_access_s acc_q, acc_d;
    tws_state_e state_q, state_d;
    logic [3:0] copy_tmpl_q, copy_tmpl_d;
    logic [5:0] copy_addr_q, copy_addr_d;
    logic copy_wr_q, copy_wr_d;
    logic [5:0] copy_wr_addr_q, copy_wr_addr_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_ofs_q, wr_ofs_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic [5:0] phase_q, phase_d;
    logic play_q, play_d;
    logic neg_q, neg_d;
    logic out_vld_q, out_vld_d;
    logic line_vld_q, line_vld_d;
    logic out_neg_q, out_neg_d;
    logic [6:0] out_q, out_d;
    tws_pkg::tws_src_e src_q, src_d;

    logic addr_phase;
    logic ram_wr;
    logic [5:0] ram_wr_addr;
    logic [6:0] ram_wr_data;
    logic [6:0] ram_acc_rd, ram_play_rd, rom_play_rd, rom_copy_rd;
    logic [3:0] play_tmpl;
    tws_pkg::tws_src_e src_now;
    logic [6:0] raw_sample;
    logic [6:0] scaled_mag;

    // Software RAM access and template copy share the single write port
    tws_sample_ram #(.DEPTH(RAM_DEPTH)) u_ram (
        .clk_sys(clk_sys),
        .wr_en(ram_wr),
        .wr_addr(ram_wr_addr),
        .wr_data(ram_wr_data),
        .rd_addr_a({acc_q.ui, acc_q.samp}),
        .rd_data_a(ram_acc_rd),
        .rd_addr_b(phase_q),
        .rd_data_b(ram_play_rd)
    );

    tws_template_rom u_rom (
        .clk_sys(clk_sys),
        .tmpl_a(play_tmpl),
        .addr_a(phase_q),
        .data_a(rom_play_rd),
        .tmpl_b(copy_tmpl_q),
        .addr_b(copy_addr_q),
        .data_b(rom_copy_rd)
    );

    // Source and ROM template implied by the pulse select code
    always_comb begin
        src_now = tws_pkg::SRC_OFF;
        play_tmpl = tws_pkg::TMPL_E1_75;
        if (ctrl_q.sel[3:2] == tws_pkg::SEL_USER_TOP) begin
            src_now = tws_pkg::SRC_USER;
        end else if (ctrl_q.sel <= tws_pkg::SEL_E1_120) begin
            src_now = tws_pkg::SRC_PRESET;
            play_tmpl = ctrl_q.sel;
        end else if (ctrl_q.sel >= tws_pkg::SEL_T1_133 && ctrl_q.sel <= tws_pkg::SEL_T1_655) begin
            src_now = tws_pkg::SRC_PRESET;
            play_tmpl = ctrl_q.sel;
        end else if (ctrl_q.sel >= tws_pkg::SEL_LBO_7P5 && ctrl_q.sel <= tws_pkg::SEL_LBO_22P5) begin
            src_now = tws_pkg::SRC_LBO;
            play_tmpl = ctrl_q.sel;
        end
    end

    // Amplitude scaling of the user waveform
    always_comb begin
        int std_v;
        int pct;
        int factor;
        int mag;
        std_v = int'(tws_pkg::SCALE_STD_T1);
        pct = tws_pkg::PCT_T1;
        factor = 0;
        mag = 0;
        if (ctrl_q.ref_tmpl == tws_pkg::TMPL_E1_120) begin
            std_v = int'(tws_pkg::SCALE_STD_E1_120);
            pct = tws_pkg::PCT_E1_120;
        end
        factor = tws_pkg::PCT_FULL + (int'(ctrl_q.scale) - std_v) * pct;
        if (factor < 0) begin
            factor = 0;
        end
        mag = (int'(ram_play_rd[5:0]) * factor) / tws_pkg::PCT_FULL;
        if (mag > int'(tws_pkg::ADDR_LAST)) begin
            mag = int'(tws_pkg::ADDR_LAST);
        end
        scaled_mag = {ram_play_rd[6], mag[5:0]};
    end

    // Preset and build-out samples bypass the scaler
    always_comb begin
        raw_sample = tws_pkg::SAMP_ZERO;
        if (src_q == tws_pkg::SRC_USER) begin
            raw_sample = scaled_mag;
        end else if (src_q != tws_pkg::SRC_OFF) begin
            raw_sample = rom_play_rd;
        end
    end

    // Playback: one sub-phase per clock, 4 UI x 16 samples
    always_comb begin
        play_d = play_q;
        phase_d = phase_q;
        neg_d = neg_q;
        src_d = src_q;
        if (!play_q && pulse_req) begin
            play_d = 1'b1;
            phase_d = '0;
            neg_d = pulse_neg;
            src_d = src_now;
        end else if (play_q) begin
            if (phase_q == tws_pkg::ADDR_LAST) begin
                play_d = 1'b0;
            end
            phase_d = phase_q + 6'h01;
        end
        out_vld_d = play_q;
        line_vld_d = out_vld_q;
        out_neg_d = neg_q;
        out_d = out_vld_q ? {raw_sample[6] ^ out_neg_q, raw_sample[5:0]} : tws_pkg::SAMP_ZERO;
    end

    // AHB-Lite slave with zero wait states
    assign addr_phase = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_comb begin
        logic [31:0] w;
        w = hwdata;
        ctrl_d = ctrl_q;
        acc_d = acc_q;
        state_d = state_q;
        copy_tmpl_d = copy_tmpl_q;
        copy_addr_d = copy_addr_q;
        copy_wr_d = 1'b0;
        copy_wr_addr_d = copy_addr_q;
        wr_pend_d = addr_phase && hwrite;
        wr_ofs_d = haddr[7:0];
        ram_wr = copy_wr_q;
        ram_wr_addr = copy_wr_addr_q;
        ram_wr_data = rom_copy_rd;
        if (wr_pend_q) begin
            if (wr_ofs_q == tws_pkg::CTRL_OFS) begin
                ctrl_d.sel = w[tws_pkg::CTRL_SEL_LSB +: tws_pkg::SEL_W];
                ctrl_d.scale = w[tws_pkg::CTRL_SCALE_LSB +: tws_pkg::SCALE_W];
                ctrl_d.ref_tmpl = w[tws_pkg::CTRL_REF_LSB +: tws_pkg::TMPL_W];
            end else if (wr_ofs_q == tws_pkg::ACCESS_OFS && state_q == ST_IDLE && !acc_q.done) begin
                acc_d.data = w[tws_pkg::ACC_DATA_LSB +: tws_pkg::SAMP_W];
                acc_d.rw = w[tws_pkg::ACC_RW_BIT];
                acc_d.samp = w[tws_pkg::ACC_SAMP_LSB +: 4];
                acc_d.ui = w[tws_pkg::ACC_UI_LSB +: 2];
                acc_d.done = w[tws_pkg::ACC_DONE_BIT];
            end else if (wr_ofs_q == tws_pkg::COPY_OFS && state_q == ST_IDLE
                         && w[tws_pkg::COPY_GO_BIT]) begin
                copy_tmpl_d = w[tws_pkg::COPY_TMPL_LSB +: tws_pkg::TMPL_W];
                copy_addr_d = '0;
                state_d = ST_COPY;
            end
        end
        case (state_q)
            ST_IDLE: begin
                if (acc_q.done && !copy_wr_q) begin
                    if (acc_q.rw) begin
                        state_d = ST_READ;
                    end else begin
                        ram_wr = 1'b1;
                        ram_wr_addr = {acc_q.ui, acc_q.samp};
                        ram_wr_data = acc_q.data;
                        acc_d.done = 1'b0;
                    end
                end
            end
            ST_READ: begin
                acc_d.data = ram_acc_rd;
                acc_d.done = 1'b0;
                state_d = ST_IDLE;
            end
            ST_COPY: begin
                copy_wr_d = 1'b1;
                copy_wr_addr_d = copy_addr_q;
                copy_addr_d = copy_addr_q + 6'h01;
                if (copy_addr_q == tws_pkg::ADDR_LAST) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Read data from next-state values so a read right after a write sees it, except the status source field, which src_now takes from ctrl_q
        hrdata_d = hrdata_q;
        if (addr_phase && !hwrite) begin
            hrdata_d = '0;
            if (haddr[7:0] == tws_pkg::CTRL_OFS) begin
                hrdata_d[tws_pkg::CTRL_SEL_LSB +: tws_pkg::SEL_W] = ctrl_d.sel;
                hrdata_d[tws_pkg::CTRL_SCALE_LSB +: tws_pkg::SCALE_W] = ctrl_d.scale;
                hrdata_d[tws_pkg::CTRL_REF_LSB +: tws_pkg::TMPL_W] = ctrl_d.ref_tmpl;
            end else if (haddr[7:0] == tws_pkg::ACCESS_OFS) begin
                hrdata_d[tws_pkg::ACC_DATA_LSB +: tws_pkg::SAMP_W] = acc_d.data;
                hrdata_d[tws_pkg::ACC_RW_BIT] = acc_d.rw;
                hrdata_d[tws_pkg::ACC_SAMP_LSB +: 4] = acc_d.samp;
                hrdata_d[tws_pkg::ACC_UI_LSB +: 2] = acc_d.ui;
                hrdata_d[tws_pkg::ACC_DONE_BIT] = acc_d.done;
            end else if (haddr[7:0] == tws_pkg::COPY_OFS) begin
                hrdata_d[tws_pkg::COPY_TMPL_LSB +: tws_pkg::TMPL_W] = copy_tmpl_d;
            end else if (haddr[7:0] == tws_pkg::STATUS_OFS) begin
                hrdata_d[tws_pkg::STAT_BUSY_BIT] = (state_d != ST_IDLE) || acc_d.done;
                hrdata_d[tws_pkg::STAT_SRC_LSB +: 2] = src_now;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctrl_q <= '0;
            acc_q <= '0;
            state_q <= ST_IDLE;
            copy_tmpl_q <= '0;
            copy_addr_q <= '0;
            copy_wr_q <= 1'b0;
            copy_wr_addr_q <= '0;
            wr_pend_q <= 1'b0;
            wr_ofs_q <= '0;
            hrdata_q <= '0;
            phase_q <= '0;
            play_q <= 1'b0;
            neg_q <= 1'b0;
            src_q <= tws_pkg::SRC_OFF;
            out_vld_q <= 1'b0;
            line_vld_q <= 1'b0;
            out_neg_q <= 1'b0;
            out_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            acc_q <= acc_d;
            state_q <= state_d;
            copy_tmpl_q <= copy_tmpl_d;
            copy_addr_q <= copy_addr_d;
            copy_wr_q <= copy_wr_d;
            copy_wr_addr_q <= copy_wr_addr_d;
            wr_pend_q <= wr_pend_d;
            wr_ofs_q <= wr_ofs_d;
            hrdata_q <= hrdata_d;
            phase_q <= phase_d;
            play_q <= play_d;
            neg_q <= neg_d;
            src_q <= src_d;
            out_vld_q <= out_vld_d;
            line_vld_q <= line_vld_d;
            out_neg_q <= out_neg_d;
            out_q <= out_d;
        end
    end

    assign line_output_pair = out_q;
    assign line_output_valid = line_vld_q;
    assign line_output_source = src_q;
endmodule : tws_shaper

/* tws_shaper_checker.sv */
// Checker for the shaper's bus answers and pulse output timing.
// Assumes single word transfers; bound to the shaper at the foot.
`timescale 1ns/1ps
module tws_shaper_checker #(
    parameter int unsigned RAM_DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic pulse_req,
    input wire logic pulse_neg,
    input wire logic [tws_pkg::SAMP_W-1:0] line_output_pair,
    input wire logic line_output_valid,
    input wire tws_pkg::tws_src_e line_output_source
);
    logic rd_req;
    logic [2:0] acc_q, acc_d;
    logic [6:0] play_q, play_d;
    logic [7:0] run_q, run_d;
    logic unmap_q, unmap_d;
    assign rd_req = hsel && htrans[1] && hready && !hwrite;
    // Track accepted pulse requests and the length of each burst
    always_comb begin
        acc_d = {acc_q[1:0], pulse_req && (play_q == 7'h00)};
        play_d = acc_d[0] ? 7'(RAM_DEPTH) : play_q - 7'(play_q != 7'h00);
        run_d = acc_q[2] ? 8'h01 : (line_output_valid ? run_q + 8'h01 : 8'h00);
        unmap_d = rd_req && (haddr[7:0] > tws_pkg::STATUS_OFS);
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            acc_q <= 3'h0;
            play_q <= 7'h00;
            run_q <= 8'h00;
            unmap_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            play_q <= play_d;
            run_q <= run_d;
            unmap_q <= unmap_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    unmap_zero_a: assert property (unmap_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!rd_req |=> $stable(hrdata))
        else $error("read data changed without a read");
    pulse_lat_a: assert property (acc_q[2] |-> line_output_valid)
        else $error("pulse did not start two cycles after request");
    pulse_len_a: assert property ($fell(line_output_valid) |-> run_q == 8'(RAM_DEPTH))
        else $error("pulse length wrong");
    valid_cause_a: assert property (line_output_valid |->
        acc_q[2] || (run_q != 8'h00 && run_q < 8'(RAM_DEPTH)))
        else $error("valid without an accepted request");
    idle_zero_a: assert property (!line_output_valid |-> line_output_pair == 7'h00)
        else $error("sample not zero while idle");
    off_zero_a: assert property (line_output_valid && line_output_source ==
        tws_pkg::SRC_OFF |-> line_output_pair == 7'h00)
        else $error("unused select code drives a sample");
    src_hold_a: assert property (line_output_valid && !acc_q[2] |->
        $stable(line_output_source))
        else $error("source changed inside a pulse");
    user_c: cover property (acc_q[2] && line_output_source == tws_pkg::SRC_USER);
    preset_c: cover property (acc_q[2] && line_output_source == tws_pkg::SRC_PRESET);
    end_c: cover property ($fell(line_output_valid));
endmodule : tws_shaper_checker

bind tws_shaper tws_shaper_checker #(.RAM_DEPTH(RAM_DEPTH)) i_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pulse_req(pulse_req),
    .pulse_neg(pulse_neg), .line_output_pair(line_output_pair),
    .line_output_valid(line_output_valid), .line_output_source(line_output_source)
);

/* tws_template_rom.sv */
// Reference waveform ROM of twelve templates, two registered read ports.
// Index = template number, address = {UI, sub-phase}.
`timescale 1ns/1ps
module tws_template_rom (
    input wire logic clk_sys,
    input wire logic [tws_pkg::TMPL_W-1:0] tmpl_a,
    input wire logic [tws_pkg::ADDR_W-1:0] addr_a,
    output logic [tws_pkg::SAMP_W-1:0] data_a,
    input wire logic [tws_pkg::TMPL_W-1:0] tmpl_b,
    input wire logic [tws_pkg::ADDR_W-1:0] addr_b,
    output logic [tws_pkg::SAMP_W-1:0] data_b
);
    // Short-haul DSX-1 shape shared by the shortest T1, J1 and 0 dB entries
    localparam logic [6:0] DSX_UI1 [16] = '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25,
        7'h25, 7'h24, 7'h23, 7'h4a, 7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43};
    localparam logic [6:0] DSX_UI2_0 = 7'h42;
    localparam logic [6:0] DSX_UI2_1 = 7'h41;

    function automatic logic [6:0] lookup(input logic [3:0] t, input logic [5:0] a);
        logic [6:0] v;
        v = tws_pkg::SAMP_ZERO;
        if (t == tws_pkg::TMPL_E1_75 || t == tws_pkg::TMPL_E1_120) begin
            if (a == tws_pkg::E1_EDGE_IDX) begin
                v = (t == tws_pkg::TMPL_E1_75) ? tws_pkg::E1_75_EDGE : tws_pkg::E1_120_EDGE;
            end else if (a > tws_pkg::E1_EDGE_IDX && a <= tws_pkg::E1_TOP_LAST) begin
                v = (t == tws_pkg::TMPL_E1_75) ? tws_pkg::E1_75_TOP : tws_pkg::E1_120_TOP;
            end
        end else if (t == tws_pkg::TMPL_T1_133 || t == tws_pkg::TMPL_J1
                     || t == tws_pkg::TMPL_LBO_0) begin
            if (a[5:4] == 2'h0) begin
                v = DSX_UI1[a[3:0]];
            end else if (a == 6'h10) begin
                v = DSX_UI2_0;
            end else if (a == 6'h11) begin
                v = DSX_UI2_1;
            end
        end
        // Remaining templates are mask-programmed; zero in this build
        return v;
    endfunction : lookup

    always_ff @(posedge clk_sys) begin
        data_a <= lookup(tmpl_a, addr_a);
        data_b <= lookup(tmpl_b, addr_b);
    end
endmodule : tws_template_rom
